/* File: verilog/cap_sense_pkg.sv */
package cap_sense_pkg;

  // ----------------------------------------------------------------
  // Field widths and channel count
  // ----------------------------------------------------------------
  localparam int CHAN_W = 4;
  localparam int NUM_CHAN = 12;
  localparam logic [CHAN_W-1:0] LAST_CHAN = 4'hb;

  // ----------------------------------------------------------------
  // Current range codes
  // ----------------------------------------------------------------
  localparam logic [1:0] RNG_OFF_NOISE = 2'h0;
  localparam logic [1:0] RNG_LOW = 2'h1;
  localparam logic [1:0] RNG_MED = 2'h2;
  localparam logic [1:0] RNG_HIGH = 2'h3;

  // Second timer source code that picks the sense oscillator
  localparam logic [1:0] T2_SRC_OSC = 2'h3;

  // ----------------------------------------------------------------
  // Clocking and reset values
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20000000;
  localparam int SYNC_W = 2;
  localparam int SYNC_OSC = 0;
  localparam int SYNC_GATE = 1;
  localparam logic [NUM_CHAN-1:0] CHAN_RST = 12'h000;
  localparam logic [1:0] LEVEL_RST = 2'h0;
  localparam logic BIT_RST = 1'b0;

endpackage

/* File: verilog/osc_sync_if.sv */
`timescale 1ns/10ps
interface osc_sync_if #(
  parameter int W = 2
);
  logic [W-1:0] level;
  logic [W-1:0] rise;

  modport producer (output level, output rise);
  modport consumer (input level, input rise);
endinterface

/* File: verilog/async_edge_sync.sv */
`timescale 1ns/10ps
module async_edge_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Asynchronous inputs
  input wire logic [W-1:0] async_i,
  // Synchronised side
  osc_sync_if.producer sync_o
);

  logic [W-1:0] meta_r;
  logic [W-1:0] stable_r;
  logic [W-1:0] prev_r;

  // ----------------------------------------------------------------
  // Two-flop synchroniser, then edge history
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= '0;
      stable_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= async_i;
      stable_r <= meta_r;
      prev_r <= stable_r;
    end
  end

  assign sync_o.level = stable_r;
  assign sync_o.rise = stable_r & ~prev_r;

  // A rise may only report an input that was high two edges earlier
  AST_RISE_ONE_CYCLE: assert property (@(posedge clk_sys_i) // RL16
    disable iff (!rst_n_i) |sync_o.rise |->
    ((sync_o.rise & ~$past(async_i, 2)) == '0))
    else $error("rise pulse without a synchronised input edge");

endmodule

/* File: verilog/capacitive_touch_osc_control.sv */
`timescale 1ns/10ps
// Notes on behaviour
// RL1: Reference mode picks variable or rail thresholds
// RL2: Range field: off, low, medium, high current
// RL3: High range code zero is noise detection
// RL4: Status bit shows oscillator source or sink
// RL5: Enabled module routes oscillator to chosen pin
// RL6: First timer clocked by oscillator when selected
// RL7: Second timer source 11 takes oscillator clock
// RL8: Second timer off, free, or gated by input
// RL9: Time base never from the oscillator-clocked timer
// RL10: Software divides count by time base period
// RL11: Suggested: first overflow toggles second gate
// RL12: Software sets sense pin analog and input
// RL13: Status one sourcing, zero sinking current
// RL14: Channels 0 to 11; reserved, disabled select none
// RL15: Enable bit runs oscillator, also in sleep
// RL16: Oscillator edges synchronised before use
module capacitive_touch_osc_control (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Sense control
  input wire logic sense_module_enable_i,
  input wire logic reference_mode_select_i,
  input wire logic [1:0] current_range_field_i,
  input wire logic [cap_sense_pkg::CHAN_W-1:0] sense_channel_select_i,
  // Timer routing control
  input wire logic first_timer_ext_source_select_i,
  input wire logic first_timer_clock_source_i,
  input wire logic [1:0] second_timer_clock_source_i,
  input wire logic second_timer_on_i,
  input wire logic second_timer_gate_enable_i,
  // Asynchronous inputs
  input wire logic osc_comparator_i,
  input wire logic second_timer_gate_i,
  // Analog control
  output logic [cap_sense_pkg::NUM_CHAN-1:0] sense_pin_n_sel_o,
  output logic ref_variable_o,
  output logic osc_run_o,
  output logic charge_current_en_o,
  output logic noise_detect_o,
  output logic [1:0] current_level_o,
  // Status
  output logic osc_direction_status_o,
  // Timer routing
  output logic first_timer_osc_sel_o,
  output logic second_timer_osc_sel_o,
  output logic second_timer_count_en_o,
  output logic first_timer_tick_o,
  output logic second_timer_tick_o
);

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic logic [cap_sense_pkg::NUM_CHAN-1:0] chan_onehot(
    input logic en,
    input logic [cap_sense_pkg::CHAN_W-1:0] ch
  );
    logic [cap_sense_pkg::NUM_CHAN-1:0] v;
    v = '0;
    if (en && ch <= cap_sense_pkg::LAST_CHAN) begin
      v[ch] = 1'b1;
    end
    return v;
  endfunction

  function automatic logic osc_running(
    input logic en,
    input logic rm,
    input logic [1:0] rng
  );
    return en && (rm || rng != cap_sense_pkg::RNG_OFF_NOISE);
  endfunction

  // ----------------------------------------------------------------
  // Synchronisation of oscillator and gate pin
  // ----------------------------------------------------------------
  osc_sync_if #(.W(cap_sense_pkg::SYNC_W)) sync_bus ();

  async_edge_sync #(.W(cap_sense_pkg::SYNC_W)) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .async_i({second_timer_gate_i, osc_comparator_i}),
    .sync_o(sync_bus.producer)
  );

  logic osc_level;
  logic osc_rise;
  logic gate_level;
  logic first_sel_nxt;
  logic second_sel_nxt;
  logic second_run_nxt;

  assign osc_level = sync_bus.level[cap_sense_pkg::SYNC_OSC]; // RL16
  assign osc_rise = sync_bus.rise[cap_sense_pkg::SYNC_OSC]; // RL16
  assign gate_level = sync_bus.level[cap_sense_pkg::SYNC_GATE];

  // ----------------------------------------------------------------
  // Channel multiplexer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sense_pin_n_sel_o <= cap_sense_pkg::CHAN_RST;
    end else begin
      sense_pin_n_sel_o <= chan_onehot(sense_module_enable_i,
        sense_channel_select_i); // RL5 RL14
    end
  end

  // ----------------------------------------------------------------
  // Reference and power mode decode
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ref_variable_o <= cap_sense_pkg::BIT_RST;
      osc_run_o <= cap_sense_pkg::BIT_RST;
      charge_current_en_o <= cap_sense_pkg::BIT_RST;
      noise_detect_o <= cap_sense_pkg::BIT_RST;
      current_level_o <= cap_sense_pkg::LEVEL_RST;
    end else begin
      ref_variable_o <= reference_mode_select_i; // RL1
      osc_run_o <= osc_running(sense_module_enable_i,
        reference_mode_select_i, current_range_field_i); // RL2 RL15
      charge_current_en_o <= sense_module_enable_i &&
        current_range_field_i != cap_sense_pkg::RNG_OFF_NOISE; // RL2 RL3
      noise_detect_o <= sense_module_enable_i && reference_mode_select_i &&
        current_range_field_i == cap_sense_pkg::RNG_OFF_NOISE; // RL3
      current_level_o <= sense_module_enable_i ?
        current_range_field_i : cap_sense_pkg::LEVEL_RST; // RL2
    end
  end

  // ----------------------------------------------------------------
  // Direction status
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      osc_direction_status_o <= cap_sense_pkg::BIT_RST;
    end else begin
      osc_direction_status_o <= osc_level; // RL4 RL13 RL16
    end
  end

  // ----------------------------------------------------------------
  // Timer clock routing and count qualification
  // ----------------------------------------------------------------
  assign first_sel_nxt = first_timer_ext_source_select_i &&
    !first_timer_clock_source_i; // RL6
  assign second_sel_nxt = second_timer_clock_source_i ==
    cap_sense_pkg::T2_SRC_OSC; // RL7
  assign second_run_nxt = second_timer_on_i &&
    (!second_timer_gate_enable_i || gate_level); // RL8

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      first_timer_osc_sel_o <= cap_sense_pkg::BIT_RST;
      second_timer_osc_sel_o <= cap_sense_pkg::BIT_RST;
      second_timer_count_en_o <= cap_sense_pkg::BIT_RST;
    end else begin
      first_timer_osc_sel_o <= first_sel_nxt; // RL6
      second_timer_osc_sel_o <= second_sel_nxt; // RL7
      second_timer_count_en_o <= second_run_nxt; // RL8
    end
  end

  // Rising oscillator edges become one-cycle count enables on the system clock
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      first_timer_tick_o <= cap_sense_pkg::BIT_RST;
      second_timer_tick_o <= cap_sense_pkg::BIT_RST;
    end else begin
      first_timer_tick_o <= first_sel_nxt && osc_rise; // RL6 RL16
      second_timer_tick_o <= second_sel_nxt && second_run_nxt &&
        osc_rise; // RL7 RL8
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_disabled;
    !sense_module_enable_i;
  endsequence

  sequence s_all_off;
    sense_pin_n_sel_o == '0 && !osc_run_o && !charge_current_en_o;
  endsequence

  AST_DISABLED_OFF: assert property (s_disabled |=> s_all_off) // RL14
    else $error("disabled module still drives pin or oscillator");

  AST_CHAN_DECODE: assert property (sense_module_enable_i && // RL5
    sense_channel_select_i <= cap_sense_pkg::LAST_CHAN |=>
    sense_pin_n_sel_o == (12'h001 << $past(sense_channel_select_i)))
    else $error("enabled channel not routed to its pin");

  AST_CHAN_RESERVED: assert property ( // RL14
    sense_channel_select_i > cap_sense_pkg::LAST_CHAN |=>
    sense_pin_n_sel_o == '0)
    else $error("reserved channel code selected a pin");

  AST_NOISE_MODE: assert property (sense_module_enable_i && // RL3
    reference_mode_select_i && current_range_field_i == 2'h0 |=>
    noise_detect_o && osc_run_o && !charge_current_en_o)
    else $error("noise mode decode wrong");

  AST_LOW_OFF: assert property (sense_module_enable_i && // RL2
    !reference_mode_select_i && current_range_field_i == 2'h0 |=>
    !osc_run_o && !noise_detect_o)
    else $error("low range code zero did not stop oscillator");

  AST_REF_SELECT: assert property (##1 ref_variable_o == // RL1
    $past(reference_mode_select_i))
    else $error("reference selection does not follow mode bit");

  AST_STATUS_LAT: assert property (osc_comparator_i [*4] |-> // RL13
    osc_direction_status_o)
    else $error("direction status missed sourcing state");

  // Count enable and tick both follow the on bit of the same edge
  AST_SECOND_OFF: assert property (!second_timer_on_i |=> // RL8
    !second_timer_count_en_o && !second_timer_tick_o)
    else $error("second timer counts while off");

  AST_FIRST_SEL: assert property (first_timer_ext_source_select_i && // RL6
    !first_timer_clock_source_i |=> first_timer_osc_sel_o)
    else $error("first timer not given oscillator clock");

  AST_SECOND_SEL: assert property (second_timer_tick_o |-> // RL7
    $past(second_timer_clock_source_i) == 2'h3)
    else $error("second timer ticked from oscillator while unselected");

endmodule

/* File: verif/sense_pad_model.sv */
`timescale 1ns/10ps
module sense_pad_model #(
  parameter int HALF_NS = 230
) (
  // Control from the block
  input wire logic osc_run_i,
  input wire logic charge_en_i,
  input wire logic noise_i,
  // Comparator level seen by the block
  output logic comparator_o
);
  // ----------------------------------------------------------------
  // Pad triangle wave
  // ----------------------------------------------------------------
  // Slower than a quarter of the system clock and out of phase with it.
  // Without charge current only injected noise moves the comparator.
  initial comparator_o = 1'b0;
  always begin
    #(HALF_NS);
    if (osc_run_i && (charge_en_i || noise_i)) begin
      comparator_o = ~comparator_o;
    end
  end
endmodule

/* File: verif/capacitive_touch_osc_control_test.sv */
`timescale 1ns/10ps
module capacitive_touch_osc_control_test;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic en = 1'b0, rm = 1'b0, t0x = 1'b0, t0cs = 1'b0;
  logic t1on = 1'b0, t1ge = 1'b0, gate = 1'b0, noise = 1'b0;
  logic [1:0] rng = 2'h0, t1cs = 2'h0, lvl;
  logic [3:0] ch = 4'h0;
  logic [11:0] pin_sel;
  logic comp, ref_var, run, chg, nz, stat, f_sel, s_sel, cnt_en, tk_a, tk_b;
  int failures = 0, num_checks = 0, cycles = 0, rises = 0, na = 0, nb = 0;

  always #25 clk_sys_i = ~clk_sys_i;
  always @(posedge comp) rises++;
  always @(posedge clk_sys_i) begin
    na += tk_a;
    nb += tk_b;
    cycles++;
    if (cycles == 5000) begin
      failures++;
      give_verdict();
    end
  end

  capacitive_touch_osc_control capacitive_touch_osc_control_i (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .sense_module_enable_i(en), .reference_mode_select_i(rm),
    .current_range_field_i(rng), .sense_channel_select_i(ch),
    .first_timer_ext_source_select_i(t0x),
    .first_timer_clock_source_i(t0cs),
    .second_timer_clock_source_i(t1cs), .second_timer_on_i(t1on),
    .second_timer_gate_enable_i(t1ge), .osc_comparator_i(comp),
    .second_timer_gate_i(gate), .sense_pin_n_sel_o(pin_sel),
    .ref_variable_o(ref_var), .osc_run_o(run), .charge_current_en_o(chg),
    .noise_detect_o(nz), .current_level_o(lvl),
    .osc_direction_status_o(stat), .first_timer_osc_sel_o(f_sel),
    .second_timer_osc_sel_o(s_sel), .second_timer_count_en_o(cnt_en),
    .first_timer_tick_o(tk_a), .second_timer_tick_o(tk_b)
  );

  sense_pad_model sense_pad_model_i (
    .osc_run_i(run), .charge_en_i(chg), .noise_i(noise),
    .comparator_o(comp)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask

  // Time base comes from the bench, not from a ticked timer
  task automatic measure(output int r, output int a, output int b);
    @(negedge clk_sys_i);
    rises = 0;
    na = 0;
    nb = 0;
    repeat (200) @(negedge clk_sys_i);
    r = rises;
    a = na;
    b = nb;
  endtask

  task automatic give_verdict();
    if (failures == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_channels();
    for (int c = 0; c < 16; c++) begin
      @(posedge clk_sys_i);
      en <= 1'b1;
      ch <= 4'(c);
      settle(2);
      check(pin_sel, (c < 12) ? 12'h001 << c : 12'h000);
    end
    @(posedge clk_sys_i);
    en <= 1'b0;
    ch <= 4'h3;
    settle(2);
    check(pin_sel, 12'h000);
  endtask

  task automatic test_ranges();
    for (int m = 0; m < 2; m++)
      for (int r = 0; r < 4; r++) begin
        @(posedge clk_sys_i);
        en <= 1'b1;
        rm <= 1'(m);
        rng <= 2'(r);
        settle(2);
        check({11'h0, ref_var}, 12'(m));
        check({10'h0, lvl}, 12'(r));
        check({11'h0, run}, 12'(m == 1 || r != 0));
        check({11'h0, chg}, 12'(r != 0));
        check({11'h0, nz}, 12'(m == 1 && r == 0));
      end
    @(posedge clk_sys_i);
    en <= 1'b0;
    settle(2);
    check({10'h0, lvl, run, chg}, 12'h000);
  endtask

  task automatic test_routing();
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_sys_i);
      {t0x, t0cs} <= 2'(k);
      t1cs <= 2'(k);
      {t1on, t1ge} <= 2'(k);
      gate <= 1'b0;
      settle(5);
      check({11'h0, f_sel}, 12'(k == 2));
      check({11'h0, s_sel}, 12'(k == 3));
      check({11'h0, cnt_en}, 12'(k == 2));
      @(posedge clk_sys_i);
      gate <= 1'b1;
      settle(5);
      check({11'h0, cnt_en}, 12'(k >= 2));
    end
  endtask

  task automatic test_ticks();
    int r, a, b;
    @(posedge clk_sys_i);
    {en, rm, rng, t0x, t0cs, t1cs, t1on, t1ge} <= 10'h26e;
    settle(5);
    measure(r, a, b);
    check(12'(r > 10 && (a - r) inside {-1, 0, 1}), 12'h001);
    check(12'((b - r) inside {-1, 0, 1}), 12'h001);
    @(posedge clk_sys_i);
    rm <= 1'b1;
    rng <= 2'h0;
    settle(5);
    measure(r, a, b);
    check(12'(r + a + b), 12'h000);
    @(posedge clk_sys_i);
    noise <= 1'b1;
    settle(5);
    measure(r, a, b);
    check(12'(r > 10 && (a - r) inside {-1, 0, 1}), 12'h001);
    noise <= 1'b0;
  endtask

  task automatic test_status();
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_sys_i);
      {en, rm, rng} <= 4'h9;
      for (int i = 0; i < 40 && comp !== 1'(k); i++) @(negedge clk_sys_i);
      @(posedge clk_sys_i);
      en <= 1'b0;
      settle(6);
      check({10'h0, comp, stat}, 12'(k * 3));
    end
  endtask

  initial begin
    repeat (20) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    test_channels();
    test_ranges();
    test_routing();
    test_ticks();
    test_status();
    give_verdict();
  end
endmodule
